// ==== fmac_pkg.sv ====
package fmac_pkg;
   // ----------------------------------------
   // Modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      FMAC_SUM4 = 2'b00,
      FMAC_FULL18 = 2'b01,
      FMAC_SUM2 = 2'b10
   } fmac_mode_t;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int unsigned FMAC_X_W = 18;
   localparam int unsigned FMAC_Y_W = 19;
   localparam int unsigned FMAC_Z_W = 18;
   localparam int unsigned FMAC_N9_W = 9;
   localparam int unsigned FMAC_RES_W = 64;
   localparam int unsigned FMAC_PROD_W = 37;
   localparam int unsigned FMAC_SCAN_W = 27;
   localparam int unsigned FMAC_SEL_W = 3;
   localparam int unsigned FMAC_COEF_N = 8;
   localparam int unsigned FMAC_ENA_N = 3;
   localparam int unsigned FMAC_CLR_N = 2;
   localparam int unsigned FMAC_PRE_W = 6;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [31:0] FMAC_PRELOAD_OFS = 32'h0000_0000;
   localparam logic [31:0] FMAC_RES_LO_OFS = 32'h0000_0004;
   localparam logic [31:0] FMAC_RES_HI_OFS = 32'h0000_0008;
   localparam logic [FMAC_PRE_W-1:0] FMAC_PRELOAD_RST = 6'h00;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [FMAC_X_W-1:0] top_x;
      logic [FMAC_Y_W-1:0] top_y;
      logic [FMAC_Z_W-1:0] top_z;
      logic [FMAC_X_W-1:0] bot_x;
      logic [FMAC_Y_W-1:0] bot_y;
      logic [FMAC_Z_W-1:0] bot_z;
      logic [FMAC_N9_W-1:0] third_x;
      logic [FMAC_N9_W-1:0] third_y;
      logic [FMAC_N9_W-1:0] fourth_x;
      logic [FMAC_N9_W-1:0] fourth_y;
      logic [FMAC_SCAN_W-1:0] scan_in;
      logic suppress;
      logic accumulate;
      logic load_const;
      logic sub;
      logic negate;
      logic use_top_y;
   } fmac_in_t;

   typedef struct packed {
      logic [FMAC_RES_W-1:0] result_a;
      logic [FMAC_PROD_W-1:0] result_b;
      logic [FMAC_RES_W-1:0] chain_out;
      logic [FMAC_SCAN_W-1:0] scan_out;
   } fmac_out_t;
endpackage

// ==== fmac_reg.sv ====
module fmac_reg #(
   parameter int unsigned W = 1,
   parameter int unsigned ENA_SEL = 0,
   parameter bit ASYNC_CLR = 1'b0
) (
   input wire logic clk_i, // Slice clock
   input wire logic reset_i, // Sync reset, high
   input wire logic [fmac_pkg::FMAC_ENA_N-1:0] ena_i, // Clock enables
   input wire logic clr_i, // Selected clear line
   input wire logic [W-1:0] d_i, // Next data
   output logic [W-1:0] q_o // Held data
);
   logic [W-1:0] q_q;
   logic [W-1:0] q_d;

   always_comb begin
      q_d = q_q;
      if (ena_i[ENA_SEL]) begin
         if (clr_i && !ASYNC_CLR) begin
            q_d = '0;
         end else begin
            q_d = d_i;
         end
      end
   end

   generate
      if (ASYNC_CLR) begin : g_async
         always_ff @(posedge clk_i or posedge clr_i) begin
            if (clr_i) begin
               q_q <= '0;
            end else if (reset_i) begin
               q_q <= '0;
            end else begin
               q_q <= q_d;
            end
         end
      end else begin : g_sync
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               q_q <= '0;
            end else begin
               q_q <= q_d;
            end
         end
      end
   endgenerate

   assign q_o = q_q;
endmodule

// ==== fmac_coef_mem.sv ====
module fmac_coef_mem #(
   parameter int unsigned W = 18,
   parameter int unsigned DEPTH = 8,
   parameter logic [DEPTH*W-1:0] COEFS = '0,
   parameter int unsigned ENA_SEL = 0,
   parameter bit ASYNC_CLR = 1'b0
) (
   input wire logic clk_i, // Slice clock
   input wire logic reset_i, // Sync reset, high
   input wire logic [fmac_pkg::FMAC_ENA_N-1:0] ena_i, // Clock enables
   input wire logic clr_i, // Input-bank clear
   input wire logic [$clog2(DEPTH)-1:0] sel_i, // Coefficient index
   output logic [W-1:0] coef_o // Registered coefficient
);
   logic [W-1:0] rd;

   always_comb begin
      rd = COEFS[sel_i*W +: W];
   end

   fmac_reg #(
      .W(W),
      .ENA_SEL(ENA_SEL),
      .ASYNC_CLR(ASYNC_CLR)
   ) u_rd (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ena_i(ena_i),
      .clr_i(clr_i),
      .d_i(rd),
      .q_o(coef_o)
   );
endmodule

// ==== fmac_slice.sv ====
// Functional notes
// - Four-product mode sums four 9x9 products onto the 64-bit result
// - Pre-adder on: top and bottom y each go through their own pre-adder
// - 18x18 modes: 18-bit x, 19-bit y; z only feeds the pre-adder
// - Independent mode gives two separate 37-bit products
// - Internal coefficients replace the top and bottom x operands
// - One clock; input, coefficient and output registers gated by a parameter-chosen enable of three
// - Two active-high clears, asynchronous or synchronous by parameter
// - Chain suppress 1 zeros the chain output, 0 forwards it; independent mode always zeros it
// - Accumulate 1 adds previous result, 0 gives current result only
// - Load constant 1 adds the preload constant, 0 adds nothing
// - Cascade select 0 takes scan input, 1 takes the top y operand
// - Three-bit coefficient select picks stored coefficient n
// - Coefficient selects only matter with internal coefficients enabled
// - Every mode has 27-bit scan in and out; scan out forwards the chosen top y, sign-extended
// - Sum-of-two: sub 0 adds products, 1 gives bottom minus top
// - Negate 1 subtracts product sum from chain input plus loopback
module fmac_slice #(
   parameter fmac_pkg::fmac_mode_t MODE = fmac_pkg::FMAC_SUM4,
   parameter bit PREADD_EN = 1'b0,
   parameter bit COEF_EN = 1'b0,
   parameter int unsigned IN_ENA = 0,
   parameter int unsigned OUT_ENA = 0,
   parameter bit ASYNC_CLR = 1'b0,
   parameter logic [fmac_pkg::FMAC_COEF_N*fmac_pkg::FMAC_X_W-1:0] COEF_TOP = '0,
   parameter logic [fmac_pkg::FMAC_COEF_N*fmac_pkg::FMAC_X_W-1:0] COEF_BOT = '0
) (
   input wire logic clk_i, // Slice clock
   input wire logic reset_i, // Sync reset, high
   input wire logic [fmac_pkg::FMAC_ENA_N-1:0] ena_i, // Clock enables
   input wire logic [fmac_pkg::FMAC_CLR_N-1:0] clr_i, // 0 inputs, 1 outputs
   input wire logic hsel_i, // AHB select
   input wire logic [31:0] haddr_i, // AHB address
   input wire logic [1:0] htrans_i, // AHB transfer type
   input wire logic hwrite_i, // AHB write
   input wire logic [2:0] hsize_i, // AHB size
   input wire logic [31:0] hwdata_i, // AHB write data
   input wire logic hready_i, // AHB ready in
   output logic [31:0] hrdata_o, // AHB read data
   output logic hreadyout_o, // AHB ready out
   output logic hresp_o, // AHB response
   input wire logic [fmac_pkg::FMAC_X_W-1:0] top_x_operand_i, // Top x
   input wire logic [fmac_pkg::FMAC_Y_W-1:0] top_y_operand_i, // Top y
   input wire logic [fmac_pkg::FMAC_Z_W-1:0] top_preadd_operand_i, // Top z
   input wire logic [fmac_pkg::FMAC_X_W-1:0] bottom_x_operand_i, // Bottom x
   input wire logic [fmac_pkg::FMAC_Y_W-1:0] bottom_y_operand_i, // Bottom y
   input wire logic [fmac_pkg::FMAC_Z_W-1:0] bottom_preadd_operand_i, // Bottom z
   input wire logic [fmac_pkg::FMAC_N9_W-1:0] third_x_operand_i, // Third x
   input wire logic [fmac_pkg::FMAC_N9_W-1:0] third_y_operand_i, // Third y
   input wire logic [fmac_pkg::FMAC_N9_W-1:0] fourth_x_operand_i, // Fourth x
   input wire logic [fmac_pkg::FMAC_N9_W-1:0] fourth_y_operand_i, // Fourth y
   input wire logic [fmac_pkg::FMAC_SEL_W-1:0] coef_sel_top_i, // Top coef index
   input wire logic [fmac_pkg::FMAC_SEL_W-1:0] coef_sel_bot_i, // Bottom coef index
   input wire logic [fmac_pkg::FMAC_SCAN_W-1:0] scan_in_i, // Scan cascade in
   input wire logic [fmac_pkg::FMAC_RES_W-1:0] chain_in_i, // Chain cascade in
   input wire logic chain_suppress_i, // Zero chain output
   input wire logic accumulate_i, // Add previous result
   input wire logic load_const_i, // Add preload constant
   input wire logic sub_i, // Bottom minus top
   input wire logic negate_i, // Subtract product sum
   input wire logic use_top_y_i, // 1 top y, 0 scan in
   output logic [fmac_pkg::FMAC_RES_W-1:0] result_a_o, // Result / top product
   output logic [fmac_pkg::FMAC_PROD_W-1:0] result_b_o, // Bottom product
   output logic [fmac_pkg::FMAC_RES_W-1:0] chain_out_o, // Chain cascade out
   output logic [fmac_pkg::FMAC_SCAN_W-1:0] scan_out_o // Scan cascade out
);
   fmac_pkg::fmac_in_t in_d;
   fmac_pkg::fmac_in_t in_q;
   fmac_pkg::fmac_out_t out_d;
   fmac_pkg::fmac_out_t out_q;
   logic [fmac_pkg::FMAC_X_W-1:0] coef_top;
   logic [fmac_pkg::FMAC_X_W-1:0] coef_bot;
   logic [fmac_pkg::FMAC_X_W-1:0] top_xa;
   logic [fmac_pkg::FMAC_X_W-1:0] bot_xa;
   logic [fmac_pkg::FMAC_Y_W-1:0] top_ysrc;
   logic signed [19:0] top_ya;
   logic signed [19:0] bot_ya;
   logic signed [37:0] p_top;
   logic signed [37:0] p_bot;
   logic signed [17:0] n1;
   logic signed [17:0] n2;
   logic signed [17:0] n3;
   logic signed [17:0] n4;
   logic [63:0] pt64;
   logic [63:0] pb64;
   logic [63:0] prod_sum;
   logic [63:0] acc_base;
   logic [63:0] const_add;
   logic [63:0] mac_sum;
   logic ahb_go;
   logic wr_pend_q;
   logic wr_pend_d;
   logic [31:0] wr_addr_q;
   logic [31:0] wr_addr_d;
   logic [fmac_pkg::FMAC_PRE_W-1:0] preload_n_q;
   logic [fmac_pkg::FMAC_PRE_W-1:0] preload_n_d;
   logic [fmac_pkg::FMAC_PRE_W-1:0] preload_rd;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic hreadyout_q;
   logic out_en;

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   assign ahb_go = hsel_i && htrans_i[1] && hready_i;

   always_comb begin
      wr_pend_d = ahb_go && hwrite_i;
      wr_addr_d = ahb_go ? haddr_i : wr_addr_q;
      preload_n_d = preload_n_q;
      if (wr_pend_q && (wr_addr_q == fmac_pkg::FMAC_PRELOAD_OFS)) begin
         preload_n_d = hwdata_i[fmac_pkg::FMAC_PRE_W-1:0];
      end
      // Forward a write still in its data phase
      preload_rd = preload_n_d;
      hrdata_d = hrdata_q;
      if (ahb_go && !hwrite_i) begin
         unique case (haddr_i)
            fmac_pkg::FMAC_PRELOAD_OFS: hrdata_d = {26'h0, preload_rd};
            fmac_pkg::FMAC_RES_LO_OFS: hrdata_d = out_q.result_a[31:0];
            fmac_pkg::FMAC_RES_HI_OFS: hrdata_d = out_q.result_a[63:32];
            default: hrdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h0000_0000;
         preload_n_q <= fmac_pkg::FMAC_PRELOAD_RST;
         hrdata_q <= 32'h0000_0000;
         hreadyout_q <= 1'b0;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         preload_n_q <= preload_n_d;
         hrdata_q <= hrdata_d;
         hreadyout_q <= 1'b1;
      end
   end

   assign hrdata_o = hrdata_q;
   assign hreadyout_o = hreadyout_q;
   assign hresp_o = 1'b0;

   // ----------------------------------------
   // Input bank
   // ----------------------------------------
   always_comb begin
      in_d.top_x = top_x_operand_i;
      in_d.top_y = top_y_operand_i;
      in_d.top_z = top_preadd_operand_i;
      in_d.bot_x = bottom_x_operand_i;
      in_d.bot_y = bottom_y_operand_i;
      in_d.bot_z = bottom_preadd_operand_i;
      in_d.third_x = third_x_operand_i;
      in_d.third_y = third_y_operand_i;
      in_d.fourth_x = fourth_x_operand_i;
      in_d.fourth_y = fourth_y_operand_i;
      in_d.scan_in = scan_in_i;
      in_d.suppress = chain_suppress_i;
      in_d.accumulate = accumulate_i;
      in_d.load_const = load_const_i;
      in_d.sub = sub_i;
      in_d.negate = negate_i;
      in_d.use_top_y = use_top_y_i;
   end

   fmac_reg #(.W($bits(fmac_pkg::fmac_in_t)), .ENA_SEL(IN_ENA), .ASYNC_CLR(ASYNC_CLR)) u_in (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ena_i(ena_i),
      .clr_i(clr_i[0]),
      .d_i(in_d),
      .q_o(in_q)
   );

   // selects feed only the coefficient stores
   fmac_coef_mem #(.W(fmac_pkg::FMAC_X_W), .DEPTH(fmac_pkg::FMAC_COEF_N), .COEFS(COEF_TOP),
      .ENA_SEL(IN_ENA), .ASYNC_CLR(ASYNC_CLR)) u_coef_top (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ena_i(ena_i),
      .clr_i(clr_i[0]),
      .sel_i(coef_sel_top_i),
      .coef_o(coef_top)
   );

   fmac_coef_mem #(.W(fmac_pkg::FMAC_X_W), .DEPTH(fmac_pkg::FMAC_COEF_N), .COEFS(COEF_BOT),
      .ENA_SEL(IN_ENA), .ASYNC_CLR(ASYNC_CLR)) u_coef_bot (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ena_i(ena_i),
      .clr_i(clr_i[0]),
      .sel_i(coef_sel_bot_i),
      .coef_o(coef_bot)
   );

   // ----------------------------------------
   // Multipliers and adders
   // ----------------------------------------
   always_comb begin
      top_xa = COEF_EN ? coef_top : in_q.top_x;
      bot_xa = COEF_EN ? coef_bot : in_q.bot_x;
      top_ysrc = in_q.use_top_y ? in_q.top_y : in_q.scan_in[fmac_pkg::FMAC_Y_W-1:0];
      top_ya = 20'($signed(top_ysrc));
      bot_ya = 20'($signed(in_q.bot_y));
      if (PREADD_EN) begin
         top_ya = 20'($signed(top_ysrc)) + 20'($signed(in_q.top_z));
         bot_ya = 20'($signed(in_q.bot_y)) + 20'($signed(in_q.bot_z));
      end
      p_top = 38'($signed(top_xa) * top_ya);
      p_bot = 38'($signed(bot_xa) * bot_ya);
      n1 = 18'($signed(top_xa[8:0]) * $signed(top_ya[8:0]));
      n2 = 18'($signed(bot_xa[8:0]) * $signed(bot_ya[8:0]));
      n3 = 18'($signed(in_q.third_x) * $signed(in_q.third_y));
      n4 = 18'($signed(in_q.fourth_x) * $signed(in_q.fourth_y));
      pt64 = 64'($signed(p_top[36:0]));
      pb64 = 64'($signed(p_bot[36:0]));
      unique case (MODE)
         fmac_pkg::FMAC_SUM4: prod_sum = 64'(n1) + 64'(n2) + 64'(n3) + 64'(n4);
         fmac_pkg::FMAC_SUM2: prod_sum = in_q.sub ? pb64 - pt64 : pt64 + pb64;
         default: prod_sum = pt64;
      endcase
      acc_base = chain_in_i + (in_q.accumulate ? out_q.result_a : 64'h0);
      // preload constant two to the N
      const_add = in_q.load_const ? (64'h1 << preload_n_q) : 64'h0;
      mac_sum = (in_q.negate ? acc_base - prod_sum : acc_base + prod_sum) + const_add;
   end

   // ----------------------------------------
   // Output bank
   // ----------------------------------------
   always_comb begin
      // forward the chosen top y onward
      out_d.scan_out = 27'($signed(top_ysrc));
      if (MODE == fmac_pkg::FMAC_FULL18) begin
         out_d.result_a = pt64;
         out_d.result_b = p_bot[36:0];
         out_d.chain_out = 64'h0;
      end else begin
         out_d.result_a = mac_sum;
         out_d.result_b = 37'h0;
         out_d.chain_out = in_q.suppress ? 64'h0 : mac_sum;
      end
   end

   fmac_reg #(.W($bits(fmac_pkg::fmac_out_t)), .ENA_SEL(OUT_ENA), .ASYNC_CLR(ASYNC_CLR)) u_out (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ena_i(ena_i),
      .clr_i(clr_i[1]),
      .d_i(out_d),
      .q_o(out_q)
   );

   assign result_a_o = out_q.result_a;
   assign result_b_o = out_q.result_b;
   assign chain_out_o = out_q.chain_out;
   assign scan_out_o = out_q.scan_out;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   assign out_en = ena_i[OUT_ENA];

   property p_suppress;
      @(posedge clk_i) disable iff (reset_i || clr_i != 2'b00)
      (MODE != fmac_pkg::FMAC_FULL18) && out_en && in_q.suppress |=> chain_out_o == 64'h0;
   endproperty
   a_suppress: assert property (p_suppress) else $error("chain not zeroed");

   property p_forward;
      @(posedge clk_i) disable iff (reset_i || clr_i != 2'b00)
      (MODE != fmac_pkg::FMAC_FULL18) && out_en && !in_q.suppress |=> chain_out_o == result_a_o;
   endproperty
   a_forward: assert property (p_forward) else $error("chain not forwarded");

   property p_plain;
      @(posedge clk_i) disable iff (reset_i || clr_i != 2'b00)
      (MODE != fmac_pkg::FMAC_FULL18) && out_en && !in_q.accumulate && !in_q.load_const
      && !in_q.negate && chain_in_i == 64'h0 |=> result_a_o == $past(prod_sum);
   endproperty
   a_plain: assert property (p_plain) else $error("current result wrong");

   property p_accum;
      @(posedge clk_i) disable iff (reset_i || clr_i != 2'b00)
      (MODE != fmac_pkg::FMAC_FULL18) && out_en && in_q.accumulate && !in_q.load_const
      && !in_q.negate && chain_in_i == 64'h0
      |=> result_a_o == 64'($past(result_a_o) + $past(prod_sum));
   endproperty
   a_accum: assert property (p_accum) else $error("accumulation wrong");

   property p_preload;
      @(posedge clk_i) disable iff (reset_i || clr_i != 2'b00)
      (MODE != fmac_pkg::FMAC_FULL18) && out_en && in_q.load_const && !in_q.accumulate
      && !in_q.negate && chain_in_i == 64'h0
      |=> result_a_o == 64'($past(prod_sum) + (64'h1 << $past(preload_n_q)));
   endproperty
   a_preload: assert property (p_preload) else $error("preload constant wrong");

   property p_negate;
      @(posedge clk_i) disable iff (reset_i || clr_i != 2'b00)
      (MODE != fmac_pkg::FMAC_FULL18) && out_en && in_q.negate && !in_q.accumulate
      && !in_q.load_const |=> result_a_o == 64'($past(chain_in_i) - $past(prod_sum));
   endproperty
   a_negate: assert property (p_negate) else $error("negate wrong");

   property p_hold;
      @(posedge clk_i) disable iff (reset_i || clr_i != 2'b00)
      !out_en |=> $stable(result_a_o) && $stable(chain_out_o) && $stable(scan_out_o);
   endproperty
   a_hold: assert property (p_hold) else $error("disabled register moved");

   property p_clear;
      @(posedge clk_i) disable iff (reset_i)
      clr_i[1] && (out_en || ASYNC_CLR) |=> result_a_o == 64'h0 && chain_out_o == 64'h0;
   endproperty
   a_clear: assert property (p_clear) else $error("clear missed");

   property p_scan;
      @(posedge clk_i) disable iff (reset_i || clr_i != 2'b00)
      out_en && !in_q.use_top_y |=> scan_out_o[18:0] == $past(in_q.scan_in[18:0]);
   endproperty
   a_scan: assert property (p_scan) else $error("scan select wrong");

   property p_full;
      @(posedge clk_i) disable iff (reset_i || clr_i != 2'b00)
      (MODE == fmac_pkg::FMAC_FULL18) && out_en
      |=> result_b_o == $past(p_bot[36:0]) && result_a_o == 64'($signed($past(p_top[36:0])));
   endproperty
   a_full: assert property (p_full) else $error("independent products wrong");
endmodule

// ==== fmac_nbr.sv ====
module fmac_nbr (
   input wire logic clk_i, // Slice clock
   input wire logic [fmac_pkg::FMAC_RES_W-1:0] chain_d_i, // Next chain value
   input wire logic [fmac_pkg::FMAC_SCAN_W-1:0] scan_d_i, // Next scan value
   output logic [fmac_pkg::FMAC_RES_W-1:0] chain_o, // To slice chain input
   output logic [fmac_pkg::FMAC_SCAN_W-1:0] scan_o // To slice scan input
);
   timeunit 1ns;
   timeprecision 1ps;
   // Registered like an upstream slice, so values move just after an edge
   // cascade wiring
   always_ff @(posedge clk_i) begin
      chain_o <= chain_d_i;
      scan_o <= scan_d_i;
   end
endmodule

// ==== fmac_slice_tb.sv ====
module fmac_slice_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic clk_i, reset_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
   logic [2:0] ena_i, cst, csb;
   logic [1:0] clr_i, htrans_i;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
   logic [17:0] tx, bx, tz, bz;
   logic [18:0] ty, by;
   logic [8:0] n3x, n3y, n4x, n4y;
   logic [26:0] scan_d, scan_w, scan_out_o;
   logic [63:0] chain_d, chain_w, result_a_o, chain_out_o, exp_r, fa, sa;
   logic [36:0] result_b_o, fb;
   // Distinct entries so a wrong coefficient index shows up
   localparam logic [143:0] CT = {18'h3fff8, 18'h7, 18'h6, 18'h5, 18'h4, 18'h3, 18'h2, 18'h1};
   logic sup, acc, lc, sb, ng, uty;
   int fails, n_checks;

   fmac_slice #(.MODE(fmac_pkg::FMAC_SUM2), .OUT_ENA(1)) i_dut (
      .clk_i(clk_i), .reset_i(reset_i), .ena_i(ena_i), .clr_i(clr_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .top_x_operand_i(tx),
      .top_y_operand_i(ty), .top_preadd_operand_i(tz), .bottom_x_operand_i(bx),
      .bottom_y_operand_i(by), .bottom_preadd_operand_i(bz), .third_x_operand_i(n3x),
      .third_y_operand_i(n3y), .fourth_x_operand_i(n4x), .fourth_y_operand_i(n4y),
      .coef_sel_top_i(cst), .coef_sel_bot_i(csb), .scan_in_i(scan_w), .chain_in_i(chain_w),
      .chain_suppress_i(sup), .accumulate_i(acc), .load_const_i(lc), .sub_i(sb),
      .negate_i(ng), .use_top_y_i(uty), .result_a_o(result_a_o), .result_b_o(result_b_o),
      .chain_out_o(chain_out_o), .scan_out_o(scan_out_o));

   fmac_nbr i_nbr (.clk_i(clk_i), .chain_d_i(chain_d), .scan_d_i(scan_d), .chain_o(chain_w),
      .scan_o(scan_w));

   // Same stimulus into the independent mode with pre-adders and coefficient stores
   fmac_slice #(.MODE(fmac_pkg::FMAC_FULL18), .PREADD_EN(1'b1), .COEF_EN(1'b1),
      .COEF_TOP(CT), .COEF_BOT(~CT)) i_dut_f (
      .clk_i(clk_i), .reset_i(reset_i), .ena_i(ena_i), .clr_i(clr_i), .hsel_i(1'b0),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(1'b1), .hrdata_o(), .hreadyout_o(), .hresp_o(),
      .top_x_operand_i(tx), .top_y_operand_i(ty), .top_preadd_operand_i(tz),
      .bottom_x_operand_i(bx), .bottom_y_operand_i(by), .bottom_preadd_operand_i(bz),
      .third_x_operand_i(n3x), .third_y_operand_i(n3y), .fourth_x_operand_i(n4x),
      .fourth_y_operand_i(n4y), .coef_sel_top_i(cst), .coef_sel_bot_i(csb),
      .scan_in_i(scan_w), .chain_in_i(chain_w), .chain_suppress_i(sup), .accumulate_i(acc),
      .load_const_i(lc), .sub_i(sb), .negate_i(ng), .use_top_y_i(uty), .result_a_o(fa),
      .result_b_o(fb), .chain_out_o(), .scan_out_o());

   fmac_slice #(.MODE(fmac_pkg::FMAC_SUM4)) i_dut_s (
      .clk_i(clk_i), .reset_i(reset_i), .ena_i(ena_i), .clr_i(clr_i), .hsel_i(1'b0),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(1'b1), .hrdata_o(), .hreadyout_o(), .hresp_o(),
      .top_x_operand_i(tx), .top_y_operand_i(ty), .top_preadd_operand_i(tz),
      .bottom_x_operand_i(bx), .bottom_y_operand_i(by), .bottom_preadd_operand_i(bz),
      .third_x_operand_i(n3x), .third_y_operand_i(n3y), .fourth_x_operand_i(n4x),
      .fourth_y_operand_i(n4y), .coef_sel_top_i(cst), .coef_sel_bot_i(csb),
      .scan_in_i(scan_w), .chain_in_i(chain_w), .chain_suppress_i(sup), .accumulate_i(acc),
      .load_const_i(lc), .sub_i(sb), .negate_i(ng), .use_top_y_i(uty), .result_a_o(sa),
      .result_b_o(), .chain_out_o(), .scan_out_o());

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [63:0] mac(input logic [17:0] x1, input logic [18:0] y1,
      input logic [17:0] x2, input logic [18:0] y2, input logic s, input logic n,
      input logic [63:0] base);
      logic [63:0] pt, pb, ps;
      pt = {{46{x1[17]}}, x1} * {{45{y1[18]}}, y1};
      pb = {{46{x2[17]}}, x2} * {{45{y2[18]}}, y2};
      ps = s ? pb - pt : pt + pb;
      return n ? base - ps : base + ps;
   endfunction

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Unused operands get live data too, so leaks into the result show up
   task automatic run(input logic [17:0] x1, input logic [18:0] y1, input logic [17:0] x2,
      input logic [18:0] y2, input logic [63:0] ch);
      @(posedge clk_i);
      tx <= x1;
      ty <= y1;
      bx <= x2;
      by <= y2;
      chain_d <= ch;
      {n3x, n3y, n4x, n4y} <= {x1, y1[17:0]};
      tz <= ~x1;
      bz <= ~x2;
      {cst, csb} <= y1[5:0];
      repeat (3) @(posedge clk_i);
      #1;
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] q);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= wr;
      // Only the watchdog ends a stalled wait
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      q = hrdata_o;
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      @(posedge clk_i);
      #1;
      check(result_a_o, 64'h0);
      check(hreadyout_o, 1'b1);
      check(hresp_o, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_addsub;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         sb <= i[0];
         ng <= i[1];
         run(18'h3fffd, 19'h00005, 18'h00007, 19'h7fffe, 64'h100);
         exp_r = mac(18'h3fffd, 19'h00005, 18'h00007, 19'h7fffe, i[0], i[1], 64'h100);
         check(result_a_o, exp_r);
         check(chain_out_o, exp_r);
         check(scan_out_o, 27'h0000005);
         check(sa, i[1] ? 64'h11a : 64'he6);
      end
      check(result_b_o, 37'h0);
      check(fa, 64'h7);
      check(fb, 37'h46);
      $display("test addsub done");
   endtask

   task automatic t_suppress;
      @(posedge clk_i);
      {sup, sb, ng} <= 3'b100;
      run(18'h00010, 19'h00003, 18'h3ffff, 19'h00009, 64'h0);
      check(result_a_o, mac(18'h00010, 19'h00003, 18'h3ffff, 19'h00009, 0, 0, 0));
      check(chain_out_o, 64'h0);
      sup <= 1'b0;
      $display("test suppress done");
   endtask

   task automatic t_const;
      ahb(1'b0, fmac_pkg::FMAC_PRELOAD_OFS, 32'h0, rd);
      check(rd, fmac_pkg::FMAC_PRELOAD_RST);
      ahb(1'b1, fmac_pkg::FMAC_PRELOAD_OFS, 32'h5, rd);
      ahb(1'b0, fmac_pkg::FMAC_PRELOAD_OFS, 32'h0, rd);
      check(rd, 32'h5);
      @(posedge clk_i);
      lc <= 1'b1;
      run(18'h2, 19'h3, 18'h4, 19'h5, 64'hffff_fff0_0000_0000);
      exp_r = mac(18'h2, 19'h3, 18'h4, 19'h5, 0, 0, 64'hffff_fff0_0000_0020);
      check(result_a_o, exp_r);
      ahb(1'b0, fmac_pkg::FMAC_RES_LO_OFS, 32'h0, rd);
      check(rd, exp_r[31:0]);
      ahb(1'b0, fmac_pkg::FMAC_RES_HI_OFS, 32'h0, rd);
      check(rd, exp_r[63:32]);
      ahb(1'b0, 32'h0000_0010, 32'h0, rd);
      check(rd, 32'h0);
      lc <= 1'b0;
      $display("test const done");
   endtask

   task automatic t_accum;
      run(18'h3, 19'h7fffb, 18'h1, 19'h1, 64'h0);
      exp_r = mac(18'h3, 19'h7fffb, 18'h1, 19'h1, 0, 0, 64'h0);
      check(result_a_o, exp_r);
      acc <= 1'b1;
      // Accumulation starts one output edge after the operand edge of run
      run(18'h3, 19'h7fffb, 18'h1, 19'h1, 64'h0);
      check(result_a_o, exp_r << 2);
      $display("test accum done");
   endtask

   task automatic t_hold;
      acc <= 1'b0;
      run(18'h3, 19'h7fffb, 18'h1, 19'h1, 64'h0);
      ena_i <= 3'h1;
      run(18'h100, 19'h100, 18'h100, 19'h100, 64'h55);
      check(result_a_o, exp_r);
      clr_i <= 2'h2;
      repeat (2) @(posedge clk_i);
      #1;
      check(result_a_o, exp_r);
      ena_i <= 3'h7;
      @(posedge clk_i);
      #1;
      check(result_a_o, 64'h0);
      clr_i <= 2'h0;
      $display("test hold done");
   endtask

   task automatic t_scan;
      @(posedge clk_i);
      uty <= 1'b0;
      scan_d <= 27'h2fffff0;
      run(18'h5, 19'h00003, 18'h2, 19'h3, 64'h0);
      check(result_a_o, mac(18'h5, 19'h7fff0, 18'h2, 19'h3, 0, 0, 64'h0));
      check(scan_out_o, 27'h7fffff0);
      uty <= 1'b1;
      $display("test scan done");
   endtask

   initial begin
      {reset_i, ena_i, clr_i, hsel_i, htrans_i, hwrite_i} = {1'b1, 3'h7, 6'h0};
      {haddr_i, hwdata_i, tx, bx, tz, bz, ty, by} = '0;
      {n3x, n3y, n4x, n4y, cst, csb, scan_d, chain_d} = '0;
      {sup, acc, lc, sb, ng, uty} = 6'h01;
      fails = 0;
      n_checks = 0;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      t_reset;
      t_addsub;
      t_suppress;
      t_const;
      t_accum;
      t_hold;
      t_scan;
      summarize;
   end

   initial begin
      #100000;
      fails++;
      summarize;
   end
endmodule
